// ==== hw/usbhg_map.svh ====
// Constants of the HID general purpose port: endpoint map, report sizes,
// reset values and timing counts.
// Assumes a 10 MHz core clock.
`ifndef USBHG_MAP_SVH
`define USBHG_MAP_SVH

`define USBHG_IF_PIN 1'b0
`define USBHG_IF_SM 1'b1
`define USBHG_EP_CTRL 4'h0
`define USBHG_EP_PIN_IN 4'h1
`define USBHG_EP_PIN_OUT 4'h2
`define USBHG_EP_SM_IN 4'h3
`define USBHG_EP_SM_OUT 4'h4

`define USBHG_PIN_BYTES 7
`define USBHG_PIN_LAST_IDX 3'h6
`define USBHG_PIN_LAST_TX 6'h06
`define USBHG_SM_BYTES 64
`define USBHG_SM_LAST_IDX 6'h3f
`define USBHG_SM_FULL_CNT 7'h40

`define USBHG_LAST_PORT 3'h6
`define USBHG_IMPL_MASK 56'h81ff_ffff_ffff_ff
`define USBHG_OUT_RESET 56'hff_ffff_ffff_ffff

`define USBHG_CLK_PERIOD_NS 100
`define USBHG_SAMPLE_PERIOD_NS 1000000
`define USBHG_PORT_GAP_NS 1000
`define USBHG_SAMPLE_CYC (`USBHG_SAMPLE_PERIOD_NS / `USBHG_CLK_PERIOD_NS)
`define USBHG_PORT_GAP_CYC (`USBHG_PORT_GAP_NS / `USBHG_CLK_PERIOD_NS)

`endif

// ==== hw/usbhg_pkg.sv ====
// Types shared by the HID general purpose port modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package usbhg_pkg;

  typedef enum logic [1:0] {
    USBHG_UPD_IDLE = 2'b01,
    USBHG_UPD_RUN = 2'b10
  } usbhg_upd_t;

  typedef enum logic [2:0] {
    USBHG_TX_IDLE = 3'b001,
    USBHG_TX_PIN = 3'b010,
    USBHG_TX_SM = 3'b100
  } usbhg_tx_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic v;
    logic [7:0] b;
    logic [5:0] idx;
    logic done;
    logic drop;
  } usbhg_frm_t;

  typedef struct packed {
    logic pwr_done;
    logic power_high;
    logic [55:0] out_lat;
    logic [55:0] out_buf;
    logic [3:0] out_cnt;
    usbhg_upd_t upd_st;
    logic [2:0] upd_port;
    logic [55:0] upd_data;
    logic [55:0] prev_smp;
    logic [55:0] in_rep;
    logic in_pend;
    usbhg_tx_t tx_st;
    logic [5:0] tx_idx;
    logic [55:0] tx_pin;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_last;
    logic tx_nak;
    logic tx_iface;
    logic [63:0][7:0] rep_mem;
    logic [6:0] rep_len;
    logic rep_full;
    logic susp;
    logic [55:0] prev_raw;
    logic wake_sent;
    logic wake_req;
    logic [55:0] drv_out;
    logic [55:0] drv_oe_n;
  } usbhg_state_t;

endpackage

`default_nettype wire

// ==== hw/usbhg_tick.sv ====
// Free running divider that pulses once every PERIOD clocks.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/10ps
`default_nettype none

module usbhg_tick
#(
  parameter int unsigned PERIOD = 10
)
(
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  localparam int W = $clog2(PERIOD + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } usbhg_tick_st_t;

  usbhg_tick_st_t s_q;
  usbhg_tick_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == '0)
    begin
      s_d.cnt = W'(PERIOD - 1);
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt - W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;
endmodule // usbhg_tick

`default_nettype wire

// ==== hw/usbhg_frame.sv ====
// Deframer for special mode command reports: numbers the bytes of
// each report and judges its length when the last byte arrives.
// Assumes at most one byte per clock from the USB engine.
`timescale 1ns/10ps
`default_nettype none

`include "usbhg_map.svh"

module usbhg_frame
  import usbhg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_last,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [5:0] cmd_idx,
  output logic cmd_done,
  output logic cmd_drop
);
  usbhg_frm_t s_q;
  usbhg_frm_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.v = 1'b0;
    s_d.done = 1'b0;
    s_d.drop = 1'b0;
    if (in_valid)
    begin
      // Bytes past the 64th are swallowed; the report is then dropped.
      if (s_q.cnt < `USBHG_SM_FULL_CNT)
      begin
        s_d.v = 1'b1;
        s_d.b = in_byte;
        s_d.idx = s_q.cnt[5:0];
        s_d.cnt = s_q.cnt + 7'h01;
      end
      if (in_last)
      begin
        s_d.cnt = 7'h00;
        s_d.done = (s_q.cnt == 7'(`USBHG_SM_BYTES - 1)); // R6 R22
        s_d.drop = !s_d.done;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cmd_valid = s_q.v;
  assign cmd_byte = s_q.b;
  assign cmd_idx = s_q.idx;
  assign cmd_done = s_q.done;
  assign cmd_drop = s_q.drop;
endmodule // usbhg_frame

`default_nettype wire

// ==== hw/usbhg_port.sv ====
// General purpose port logic of a full-speed HID device: endpoint
// routing, pin sampling and change reports, port-wise output update,
// open-drain pin drive, power strap, suspend and remote wakeup, and
// special mode report framing.
// Assumes a USB engine that handles endpoint 0 and all bus protocol,
// and special mode functions that claim pins through sm_own.
`timescale 1ns/10ps
`default_nettype none

`include "usbhg_map.svh"

////////////////////////////////////////////////////////////////////////
// Function
// [R1] Interface 0 pins, interface 1 special modes.
// [R2] Endpoint 0 control stays with engine.
// [R3] Pin changes queue reports on endpoint 1.
// [R4] Data leaves only when the host polls.
// [R5] Seven byte endpoint 2 report sets pins.
// [R6] Commands: endpoint 4, 63 bytes after ID.
// [R7] Special mode replies leave on endpoint 3.
// [R8] Host needs USB 1.1 interrupt out.
// [R9] Sample pins each millisecond, report differences.
// [R10] Owned pins excluded from detection and report.
// [R11] Reports at 1 ms, latency within 2 ms.
// [R12] Update port by port, about 1 us apart.
// [R13] Every pin always readable as input.
// [R14] Output bit 0 pulls pin low.
// [R15] Output bit 1 releases pin to pull-up.
// [R16] Strap at reset selects 100 or 500 mA.
// [R17] Externally powered boards strap for 100 mA.
// [R18] Suspend releases every pin high.
// [R19] Suspended pin change wakes host if enabled.
// [R20] Special mode takes its pins from ports.
// [R21] Interface 1 is endpoints 3 and 4.
// [R22] Special mode reports are 64 bytes with ID.
// [R23] Host writes unused port 6 bits as 1.
// [R24] Owned pins ignore port output reports.
// [R25] Output latches reset to all ones.
module usbhg_port
  import usbhg_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `USBHG_SAMPLE_CYC,
  parameter int unsigned GAP_CYC = `USBHG_PORT_GAP_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [55:0] pin_in,
  output logic [55:0] pin_out,
  output logic [55:0] pin_oe_n,
  input wire logic power_class_strap_pin,
  output logic power_high,
  input wire logic usb_suspend,
  input wire logic remote_wake_en,
  output logic remote_wake_req,
  input wire logic ep_out_valid,
  input wire logic [3:0] ep_out_ep,
  input wire logic [7:0] ep_out_byte,
  input wire logic ep_out_last,
  input wire logic ep_in_poll,
  input wire logic [3:0] ep_in_ep,
  output logic ep_in_valid,
  output logic [7:0] ep_in_byte,
  output logic ep_in_last,
  output logic ep_in_nak,
  output logic ep_in_iface,
  input wire logic [55:0] sm_own,
  input wire logic [55:0] sm_out,
  input wire logic [55:0] sm_oe_n,
  output logic sm_cmd_valid,
  output logic [7:0] sm_cmd_byte,
  output logic [5:0] sm_cmd_idx,
  output logic sm_cmd_done,
  output logic sm_cmd_drop,
  input wire logic sm_rep_valid,
  input wire logic [7:0] sm_rep_byte,
  input wire logic sm_rep_last,
  output logic sm_rep_ready
);

  //////////////////////////////////////////////////////////////////////
  // Time bases and command deframer.

  logic ms_tick;
  logic us_tick;
  logic cmd_in_valid;
  logic [55:0] smp;
  logic [55:0] own;

  usbhg_tick #(.PERIOD(SAMPLE_CYC)) u_ms_tick
  (
    .clk(clk),
    .reset_n(reset_n),
    .tick(ms_tick)
  );

  usbhg_tick #(.PERIOD(GAP_CYC)) u_us_tick
  (
    .clk(clk),
    .reset_n(reset_n),
    .tick(us_tick)
  );

  assign cmd_in_valid = ep_out_valid && (ep_out_ep == `USBHG_EP_SM_OUT); // R21

  usbhg_frame u_frame
  (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(cmd_in_valid),
    .in_byte(ep_out_byte),
    .in_last(ep_out_last),
    .cmd_valid(sm_cmd_valid),
    .cmd_byte(sm_cmd_byte),
    .cmd_idx(sm_cmd_idx),
    .cmd_done(sm_cmd_done),
    .cmd_drop(sm_cmd_drop)
  );

  //////////////////////////////////////////////////////////////////////
  // State.

  usbhg_state_t s_q;
  usbhg_state_t s_d;

  // Ownership only covers pins that exist.
  assign own = sm_own & `USBHG_IMPL_MASK; // R20

  // Owned pins read as 0, missing port 6 pins read as 1.
  assign smp = (pin_in | ~`USBHG_IMPL_MASK) & ~own; // R10 R13

  always_comb
  begin
    s_d = s_q;
    s_d.tx_valid = 1'b0;
    s_d.tx_last = 1'b0;
    s_d.tx_nak = 1'b0;
    s_d.wake_req = 1'b0;

    // The strap is caught on the first clock after reset release.
    if (!s_q.pwr_done)
    begin
      s_d.pwr_done = 1'b1;
      s_d.power_high = power_class_strap_pin; // R16
    end

    // Pin output report assembly; endpoint 0 traffic never comes here.
    if (ep_out_valid && (ep_out_ep == `USBHG_EP_PIN_OUT)) // R2
    begin
      if (s_q.out_cnt < 4'(`USBHG_PIN_BYTES))
        s_d.out_buf[{s_q.out_cnt[2:0], 3'b000} +: 8] = ep_out_byte;
      if (s_q.out_cnt != 4'hf)
        s_d.out_cnt = s_q.out_cnt + 4'h1;
      if (ep_out_last)
      begin
        s_d.out_cnt = 4'h0;
        // Reports of the wrong length are dropped whole.
        if (s_q.out_cnt == {1'b0, `USBHG_PIN_LAST_IDX}) // R5
        begin
          s_d.upd_data = s_d.out_buf;
          s_d.upd_port = 3'h0;
          s_d.upd_st = USBHG_UPD_RUN;
        end
      end
    end

    // Port-wise update, one byte per microsecond tick.
    case (s_q.upd_st)
      USBHG_UPD_IDLE:
      begin
      end
      USBHG_UPD_RUN:
      begin
        if (us_tick && (s_d.upd_st == USBHG_UPD_RUN) &&
            !(ep_out_valid && ep_out_last &&
              ep_out_ep == `USBHG_EP_PIN_OUT))
        begin
          s_d.out_lat[{s_q.upd_port, 3'b000} +: 8] =
            s_q.upd_data[{s_q.upd_port, 3'b000} +: 8]; // R5 R12
          if (s_q.upd_port == `USBHG_LAST_PORT)
            s_d.upd_st = USBHG_UPD_IDLE;
          else
            s_d.upd_port = s_q.upd_port + 3'h1; // R12
        end
      end
      default:
        s_d.upd_st = USBHG_UPD_IDLE;
    endcase

    // While a function owns a pin its latch is parked high, so the
    // pin comes back released when the function lets it go.
    s_d.out_lat = s_d.out_lat | own; // R24

    // Endpoint 1 and 3 answers, only in reply to a host poll.
    case (s_q.tx_st)
      USBHG_TX_IDLE:
      begin
        if (ep_in_poll) // R4
        begin
          case (ep_in_ep)
            `USBHG_EP_PIN_IN:
            begin
              if (s_q.in_pend)
              begin
                s_d.tx_pin = s_q.in_rep;
                s_d.in_pend = 1'b0;
                s_d.tx_idx = 6'h00;
                s_d.tx_iface = `USBHG_IF_PIN; // R1
                s_d.tx_st = USBHG_TX_PIN; // R3
              end
              else
                s_d.tx_nak = 1'b1;
            end
            `USBHG_EP_SM_IN:
            begin
              if (s_q.rep_full)
              begin
                s_d.tx_idx = 6'h00;
                s_d.tx_iface = `USBHG_IF_SM; // R1 R21
                s_d.tx_st = USBHG_TX_SM; // R7
              end
              else
                s_d.tx_nak = 1'b1;
            end
            default:
            begin
            end
          endcase
        end
      end
      USBHG_TX_PIN:
      begin
        s_d.tx_valid = 1'b1;
        s_d.tx_byte = s_q.tx_pin[{s_q.tx_idx[2:0], 3'b000} +: 8];
        s_d.tx_last = (s_q.tx_idx == `USBHG_PIN_LAST_TX);
        s_d.tx_idx = s_q.tx_idx + 6'h01;
        if (s_d.tx_last)
          s_d.tx_st = USBHG_TX_IDLE;
      end
      USBHG_TX_SM:
      begin
        s_d.tx_valid = 1'b1;
        // Short replies are padded with zero up to the full 64 bytes.
        if ({1'b0, s_q.tx_idx} < s_q.rep_len)
          s_d.tx_byte = s_q.rep_mem[s_q.tx_idx];
        else
          s_d.tx_byte = 8'h00; // R22
        s_d.tx_last = (s_q.tx_idx == `USBHG_SM_LAST_IDX); // R22
        s_d.tx_idx = s_q.tx_idx + 6'h01;
        if (s_d.tx_last)
        begin
          s_d.rep_full = 1'b0;
          s_d.rep_len = 7'h00;
          s_d.tx_st = USBHG_TX_IDLE;
        end
      end
      default:
        s_d.tx_st = USBHG_TX_IDLE;
    endcase

    // Reply capture from the special mode functions; one reply is
    // held at a time and further ones wait on sm_rep_ready.
    if (sm_rep_valid && !s_q.rep_full)
    begin
      s_d.rep_mem[s_q.rep_len[5:0]] = sm_rep_byte; // R7
      s_d.rep_len = s_q.rep_len + 7'h01;
      if (sm_rep_last || (s_q.rep_len[5:0] == `USBHG_SM_LAST_IDX))
        s_d.rep_full = 1'b1;
    end

    // Millisecond sampling; it runs after the poll logic above so a
    // new change wins over the clear of the pending flag.
    if (ms_tick && !s_q.susp) // R9 R11
    begin
      s_d.prev_smp = smp;
      if (smp != s_q.prev_smp) // R9 R10
      begin
        s_d.in_rep = smp;
        s_d.in_pend = 1'b1; // R3
      end
    end

    // Suspend and remote wakeup; one request per suspend period.
    s_d.susp = usb_suspend;
    s_d.prev_raw = pin_in;
    if (usb_suspend && !s_q.susp)
      s_d.wake_sent = 1'b0;
    if (s_q.susp && usb_suspend && remote_wake_en && !s_q.wake_sent &&
        (((pin_in ^ s_q.prev_raw) & `USBHG_IMPL_MASK) != 56'h0)) // R19
    begin
      s_d.wake_req = 1'b1;
      s_d.wake_sent = 1'b1;
    end

    // Open drain drive: a 0 latch pulls low, a 1 latch releases.
    if (s_q.susp)
    begin
      s_d.drv_oe_n = {56{1'b1}}; // R18
      s_d.drv_out = 56'h0;
    end
    else
    begin
      s_d.drv_oe_n = (own & sm_oe_n) | (~own & s_q.out_lat) |
                     ~`USBHG_IMPL_MASK; // R14 R15 R20 R23
      s_d.drv_out = own & sm_out; // R14 R20
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.out_lat <= `USBHG_OUT_RESET; // R25
      s_q.upd_st <= USBHG_UPD_IDLE;
      s_q.tx_st <= USBHG_TX_IDLE;
      s_q.drv_oe_n <= {56{1'b1}};
    end
    else
      s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs.

  assign pin_out = s_q.drv_out;
  assign pin_oe_n = s_q.drv_oe_n;
  assign power_high = s_q.power_high;
  assign remote_wake_req = s_q.wake_req;
  assign ep_in_valid = s_q.tx_valid;
  assign ep_in_byte = s_q.tx_byte;
  assign ep_in_last = s_q.tx_last;
  assign ep_in_nak = s_q.tx_nak;
  assign ep_in_iface = s_q.tx_iface;
  assign sm_rep_ready = !s_q.rep_full;
endmodule // usbhg_port

`default_nettype wire

// ==== sim/usbhg_port_chk.sv ====
// Checker for the HID general purpose port: watches the top module's
// ports only. Assumes one clock and a synchronous active low reset.
`timescale 1ns/10ps
`default_nettype none

`include "usbhg_map.svh"

module usbhg_port_chk
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [55:0] pin_oe_n,
  input wire logic power_high,
  input wire logic usb_suspend,
  input wire logic remote_wake_en,
  input wire logic remote_wake_req,
  input wire logic ep_out_valid,
  input wire logic [3:0] ep_out_ep,
  input wire logic [7:0] ep_out_byte,
  input wire logic ep_in_poll,
  input wire logic ep_in_valid,
  input wire logic ep_in_last,
  input wire logic ep_in_nak,
  input wire logic ep_in_iface,
  input wire logic sm_cmd_valid,
  input wire logic [7:0] sm_cmd_byte,
  input wire logic [5:0] sm_cmd_idx,
  input wire logic sm_cmd_done,
  input wire logic sm_cmd_drop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Counts the IN bytes already streamed in the current report.
  logic [6:0] run_q;
  always_ff @(posedge clk)
  begin
    if (!reset_n || !ep_in_valid)
      run_q <= 7'h00;
    else
      run_q <= run_q + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////
  a_susp_release: assert property (usb_suspend [*3] |=> &pin_oe_n)
    else $error("pins not released while suspended");
  a_unimpl_free: assert property ((pin_oe_n | `USBHG_IMPL_MASK) == '1)
    else $error("missing pin driven");
  a_in_asked: assert property (
    $rose(ep_in_valid) |-> $past(ep_in_poll, 2))
    else $error("IN data without a poll");
  a_nak_asked: assert property (
    ep_in_nak |-> $past(ep_in_poll) && !ep_in_valid)
    else $error("nak without a poll");
  a_pin_len: assert property (
    ep_in_last && !ep_in_iface |-> ep_in_valid && run_q == 7'h06)
    else $error("pin report not seven bytes");
  a_sm_len: assert property (
    ep_in_last && ep_in_iface |-> ep_in_valid && run_q == 7'h3f)
    else $error("reply report not 64 bytes");
  a_cmd_pass: assert property (
    sm_cmd_valid |-> $past(ep_out_valid) &&
    $past(ep_out_ep) == `USBHG_EP_SM_OUT &&
    sm_cmd_byte == $past(ep_out_byte))
    else $error("command byte not from endpoint 4");
  a_done_last: assert property (
    sm_cmd_done |-> sm_cmd_valid && sm_cmd_idx == 6'h3f)
    else $error("command done off the 64th byte");
  a_wake_cond: assert property (
    remote_wake_req |-> $past(remote_wake_en) && $past(usb_suspend))
    else $error("wake request not allowed");
  a_strap_hold: assert property (
    $past(reset_n, 2) && $past(reset_n) |-> $stable(power_high))
    else $error("power class changed after reset");

  c_wake: cover property (remote_wake_req);
  c_drop: cover property (sm_cmd_drop);
  c_reply: cover property (ep_in_last && ep_in_iface);
endmodule // usbhg_port_chk

`default_nettype wire

// ==== sim/usbhg_host.sv ====
// Host side model: polls one IN endpoint at a fixed period and captures
// the streamed report. Assumes the port's IN answer timing.
`timescale 1ns/10ps
`default_nettype none

module usbhg_host
#(
  parameter int PERIOD = 70
)
(
  input wire logic clk,
  input wire logic poll_en,
  input wire logic [3:0] host_ep,
  output logic ep_in_poll,
  output logic [3:0] ep_in_ep,
  input wire logic ep_in_valid,
  input wire logic [7:0] ep_in_byte,
  input wire logic ep_in_last,
  input wire logic ep_in_nak,
  input wire logic ep_in_iface,
  output logic [63:0][7:0] host_rx,
  output logic host_iface,
  output int reports,
  output int naks
);
  int t = 0;
  int n = 0;
  initial
  begin
    ep_in_poll = 1'b0;
    host_rx = '0;
    host_iface = 1'b0;
    reports = 0;
    naks = 0;
  end
  assign ep_in_ep = host_ep;

  // The period exceeds the longest stream, so a poll never overlaps one.
  always @(negedge clk)
  begin
    t = (t + 1) % PERIOD;
    ep_in_poll = poll_en && t == 0;
  end

  always @(posedge clk)
  begin
    if (ep_in_valid)
    begin
      host_rx[n] = ep_in_byte;
      host_iface = ep_in_iface;
      n = ep_in_last ? 0 : n + 1;
      reports += int'(ep_in_last);
    end
    naks += int'(ep_in_nak);
  end
endmodule // usbhg_host

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench of the HID general purpose port with a polling
// host model. Assumes short sample and port gap counts.
`timescale 1ns/10ps
`default_nettype none

`include "usbhg_map.svh"

module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_class_strap_pin = 1'b0;
  logic usb_suspend = 1'b0;
  logic remote_wake_en = 1'b0;
  logic ep_out_valid = 1'b0;
  logic ep_out_last = 1'b0;
  logic [3:0] ep_out_ep = 4'h0;
  logic [7:0] ep_out_byte = 8'h00;
  logic sm_rep_valid = 1'b0;
  logic sm_rep_last = 1'b0;
  logic [7:0] sm_rep_byte = 8'h00;
  logic poll_en = 1'b0;
  logic [3:0] host_ep = 4'h1;
  logic [55:0] ext = '1;
  logic [55:0] sm_own = 56'h00_0000_0000_f000;
  logic [55:0] sm_out = '0;
  logic [55:0] sm_oe_n = '1;
  logic [55:0] pin_in, pin_out, pin_oe_n;
  logic [63:0][7:0] host_rx;
  logic [7:0] ep_in_byte, sm_cmd_byte;
  logic [5:0] sm_cmd_idx;
  logic [3:0] ep_in_ep;
  logic power_high, remote_wake_req, ep_in_poll, ep_in_valid, ep_in_last;
  logic ep_in_nak, ep_in_iface, sm_cmd_valid, sm_cmd_done, sm_cmd_drop;
  logic sm_rep_ready, host_iface;
  int reports, naks, failures = 0, n_compared = 0;
  int cmd_n = 0, done_n = 0, drop_n = 0, wake_n = 0;

  always #50 clk = ~clk;
  // Released pins follow the outside level; a driven pin shows its drive.
  assign pin_in = (ext & pin_oe_n) | (pin_out & ~pin_oe_n);

  usbhg_port #(.SAMPLE_CYC(50), .GAP_CYC(3)) i_usbhg_port
  (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .power_class_strap_pin(power_class_strap_pin),
    .power_high(power_high),
    .usb_suspend(usb_suspend),
    .remote_wake_en(remote_wake_en),
    .remote_wake_req(remote_wake_req),
    .ep_out_valid(ep_out_valid),
    .ep_out_ep(ep_out_ep),
    .ep_out_byte(ep_out_byte),
    .ep_out_last(ep_out_last),
    .ep_in_poll(ep_in_poll),
    .ep_in_ep(ep_in_ep),
    .ep_in_valid(ep_in_valid),
    .ep_in_byte(ep_in_byte),
    .ep_in_last(ep_in_last),
    .ep_in_nak(ep_in_nak),
    .ep_in_iface(ep_in_iface),
    .sm_own(sm_own),
    .sm_out(sm_out),
    .sm_oe_n(sm_oe_n),
    .sm_cmd_valid(sm_cmd_valid),
    .sm_cmd_byte(sm_cmd_byte),
    .sm_cmd_idx(sm_cmd_idx),
    .sm_cmd_done(sm_cmd_done),
    .sm_cmd_drop(sm_cmd_drop),
    .sm_rep_valid(sm_rep_valid),
    .sm_rep_byte(sm_rep_byte),
    .sm_rep_last(sm_rep_last),
    .sm_rep_ready(sm_rep_ready)
  );

  usbhg_host i_usbhg_host
  (
    .clk(clk),
    .poll_en(poll_en),
    .host_ep(host_ep),
    .ep_in_poll(ep_in_poll),
    .ep_in_ep(ep_in_ep),
    .ep_in_valid(ep_in_valid),
    .ep_in_byte(ep_in_byte),
    .ep_in_last(ep_in_last),
    .ep_in_nak(ep_in_nak),
    .ep_in_iface(ep_in_iface),
    .host_rx(host_rx),
    .host_iface(host_iface),
    .reports(reports),
    .naks(naks)
  );

  always @(posedge clk)
  begin
    cmd_n += int'(sm_cmd_valid);
    done_n += int'(sm_cmd_done);
    drop_n += int'(sm_cmd_drop);
    wake_n += int'(remote_wake_req);
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic send(logic [3:0] ep, int n, logic [63:0][7:0] d);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      ep_out_valid = 1'b1;
      ep_out_ep = ep;
      ep_out_byte = d[i];
      ep_out_last = (i == n - 1);
    end
    @(negedge clk);
    ep_out_valid = 1'b0;
    ep_out_byte = ~ep_out_byte;
  endtask

  task automatic do_reset(logic strap);
    @(negedge clk);
    reset_n = 1'b0;
    power_class_strap_pin = strap;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    check("power_high", power_high, strap);
    check("oe_reset", pin_oe_n, `USBHG_OUT_RESET);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_in;
    int r, k, w;
    logic [55:0] exp;
    poll_en = 1'b1;
    repeat (300) @(negedge clk);
    k = naks;
    r = reports;
    repeat (150) @(negedge clk);
    check("idle_nak", naks > k, 1);
    ext = 56'h12_3456_789a_bcde;
    exp = (ext & ~sm_own & `USBHG_IMPL_MASK) | ~`USBHG_IMPL_MASK;
    for (w = 0; w < 300 && reports == r; w++)
      @(negedge clk);
    check("latency_ok", w <= 180, 1);
    check("in_report", host_rx[6:0], exp);
    check("in_iface", host_iface, 0);
  endtask

  task automatic t_cmd;
    logic [63:0][7:0] d;
    int c;
    for (int i = 0; i < 64; i++)
      d[i] = i[7:0] ^ 8'h3c;
    c = cmd_n;
    send(4'h4, 64, d);
    repeat (3) @(negedge clk);
    check("cmd_bytes", cmd_n - c, 64);
    check("cmd_done", done_n, 1);
    send(4'h4, 10, d);
    repeat (3) @(negedge clk);
    check("cmd_drop", drop_n, 1);
  endtask

  task automatic t_reply;
    int r, w;
    r = reports;
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk);
      sm_rep_valid = 1'b1;
      sm_rep_byte = 8'ha0 + i[7:0];
      sm_rep_last = (i == 4);
      do @(posedge clk); while (sm_rep_ready !== 1'b1);
    end
    @(negedge clk);
    sm_rep_valid = 1'b0;
    sm_rep_byte = ~sm_rep_byte;
    host_ep = 4'h3;
    for (w = 0; w < 300 && reports == r; w++)
      @(negedge clk);
    check("reply", host_rx[4:0], 40'ha4_a3a2_a1a0);
    check("reply_pad", |host_rx[63:5], 0);
    check("reply_iface", host_iface, 1);
  endtask

  task automatic t_pins;
    logic [63:0][7:0] d;
    logic [55:0] exp;
    int t [7];
    d = '0;
    d[6:0] = 56'h7e_f0a5_0f5a_0000;
    exp = d[6:0] | sm_own;
    send(4'h2, 6, d);
    send(4'h0, 7, d);
    repeat (20) @(negedge clk);
    check("short_ignored", pin_oe_n, `USBHG_OUT_RESET);
    send(4'h2, 7, d);
    t = '{default: -1};
    for (int c = 0; c < 60; c++)
    begin
      @(negedge clk);
      for (int k = 0; k < 7; k++)
        if (t[k] < 0 && pin_oe_n[8*k +: 8] === exp[8*k +: 8])
          t[k] = c;
    end
    for (int k = 1; k < 7; k++)
      check("port_gap", t[k] - t[k-1], 3);
    check("oe_pins", pin_oe_n, exp);
    check("drive_low", pin_out & ~pin_oe_n, 0);
    sm_oe_n[13] = 1'b0;
    sm_out[13] = 1'b1;
    repeat (2) @(negedge clk);
    check("owned_drive", {pin_oe_n[13], pin_out[13]}, 2'b01);
    sm_oe_n = '1;
    sm_out = '0;
  endtask

  task automatic t_susp;
    poll_en = 1'b0;
    usb_suspend = 1'b1;
    repeat (5) @(negedge clk);
    check("susp_oe", pin_oe_n, `USBHG_OUT_RESET);
    ext[40] = ~ext[40];
    repeat (5) @(negedge clk);
    check("wake_off", wake_n, 0);
    remote_wake_en = 1'b1;
    @(negedge clk);
    ext[40] = ~ext[40];
    repeat (5) @(negedge clk);
    ext[40] = ~ext[40];
    repeat (5) @(negedge clk);
    check("wake_once", wake_n, 1);
    usb_suspend = 1'b0;
  endtask

  initial
  begin
    do_reset(1'b0);
    do_reset(1'b1);
    t_in();
    t_cmd();
    t_reply();
    t_pins();
    t_susp();
    test_done();
  end

  // The tests take under 2000 cycles; ten thousand means a hang.
  initial
  begin
    #1000000;
    failures++;
    test_done();
  end
endmodule // tb

bind usbhg_port usbhg_port_chk i_usbhg_port_chk
(
  .clk(clk),
  .reset_n(reset_n),
  .pin_oe_n(pin_oe_n),
  .power_high(power_high),
  .usb_suspend(usb_suspend),
  .remote_wake_en(remote_wake_en),
  .remote_wake_req(remote_wake_req),
  .ep_out_valid(ep_out_valid),
  .ep_out_ep(ep_out_ep),
  .ep_out_byte(ep_out_byte),
  .ep_in_poll(ep_in_poll),
  .ep_in_valid(ep_in_valid),
  .ep_in_last(ep_in_last),
  .ep_in_nak(ep_in_nak),
  .ep_in_iface(ep_in_iface),
  .sm_cmd_valid(sm_cmd_valid),
  .sm_cmd_byte(sm_cmd_byte),
  .sm_cmd_idx(sm_cmd_idx),
  .sm_cmd_done(sm_cmd_done),
  .sm_cmd_drop(sm_cmd_drop)
);

`default_nettype wire
